// File: design/twr_pkg.sv
// Purpose: shared constants, types and parity helpers for the telemetry word receiver
// Assumes: 10 MHz core clock, serial link at a fixed bit rate
// Notes: parity generator is a serial 7-bit polynomial divider, polynomial is a parameter
package twr_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int BAUD_HZ = 1200;
	// one bit time in clock cycles, rounded down
	localparam int BIT_CYC_DEF = CLK_HZ / BAUD_HZ;
	// preparatory portion: 5.5 bit times, counted in half bits
	localparam int PREP_HALVES = 11;
	localparam int TMR_W = 20;

	// ****************************************
	// word layout
	// ****************************************
	localparam int INFO_BITS = 17;
	localparam int PAR_BITS = 7;
	localparam int TAIL_BITS = 1 + INFO_BITS + PAR_BITS;
	localparam int BCNT_W = 5;
	localparam int CMD_GRP_BIT = 3;
	localparam int GROUP_LSB = 4;
	localparam int GROUP_W = 4;
	localparam int ADDR_LSB_DEF = 10;
	localparam int ADDR_W_DEF = 6;
	localparam logic [PAR_BITS-1:0] PAR_POLY_DEF = 7'h45;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic LINE_IDLE = 1'b1;
	localparam logic [INFO_BITS-1:0] INFO_RST = 17'h0_0000;
	localparam logic [PAR_BITS-1:0] PAR_RST = 7'h00;
	localparam logic [GROUP_W-1:0] GROUP_RST = 4'h0;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {RX_HUNT, RX_START, RX_INFO, RX_PARITY, RX_CHECK} twr_rx_state_t;
	typedef enum logic [1:0] {TX_IDLE, TX_PREP, TX_SEND} twr_tx_state_t;

	typedef struct packed {
		logic accept;
		logic err;
		logic drop;
		logic grp_req;
	} twr_evt_t;

	typedef struct packed {
		logic start;
		logic [INFO_BITS-1:0] info;
	} twr_tx_req_t;

	// ****************************************
	// parity helpers
	// ****************************************
	function automatic logic [PAR_BITS-1:0] twr_par_step(input logic [PAR_BITS-1:0] crc, input logic b,
		input logic [PAR_BITS-1:0] poly);
		logic fb;
		fb = b ^ crc[PAR_BITS-1];
		return {crc[PAR_BITS-2:0], 1'b0} ^ (fb ? poly : PAR_RST);
	endfunction

	function automatic logic [PAR_BITS-1:0] twr_parity(input logic [INFO_BITS-1:0] info,
		input logic [PAR_BITS-1:0] poly);
		logic [PAR_BITS-1:0] crc;
		crc = PAR_RST;
		for (int i = INFO_BITS - 1; i >= 0; i--)
		begin
			crc = twr_par_step(crc, info[i], poly);
		end
		return crc;
	endfunction

endpackage

// File: design/twr_tx.sv
// Purpose: outgoing word assembler for the telemetry word receiver
// Assumes: request pulse comes from logic on core_clk
// Notes: requests while busy are ignored
`timescale 1ns/1ns
module twr_tx import twr_pkg::*; #(
	parameter int BIT_CYC = BIT_CYC_DEF,
	parameter logic [PAR_BITS-1:0] PAR_POLY = PAR_POLY_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// request
	input wire twr_tx_req_t tx_req,
	output logic tx_busy,
	// link
	output logic tx_line
);

	// ****************************************
	// state
	// ****************************************
	twr_tx_state_t state_q;
	logic [TMR_W-1:0] tmr_q;
	logic [BCNT_W-1:0] cnt_q;
	logic [TAIL_BITS-1:0] sh_q;
	logic line_q;
	logic busy_q;

	wire half_done = tmr_q == TMR_W'(BIT_CYC / 2 - 1);
	wire bit_done = tmr_q == TMR_W'(BIT_CYC - 1);
	wire [PAR_BITS-1:0] par = twr_parity(tx_req.info, PAR_POLY);

	assign tx_busy = busy_q;
	assign tx_line = line_q;

	// ****************************************
	// prep half bits, then start, info and parity
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_q <= TX_IDLE;
			tmr_q <= '0;
			cnt_q <= '0;
			sh_q <= '0;
			line_q <= LINE_IDLE;
			busy_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				TX_IDLE:
				begin
					tmr_q <= '0;
					cnt_q <= '0;
					if (tx_req.start)
					begin
						sh_q <= {1'b0, tx_req.info, par};
						state_q <= TX_PREP;
						busy_q <= 1'b1;
						line_q <= LINE_IDLE;
					end
				end
				TX_PREP:
				begin
					tmr_q <= half_done ? '0 : tmr_q + 1'b1;
					if (half_done)
					begin
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == BCNT_W'(PREP_HALVES - 1))
						begin
							cnt_q <= '0;
							state_q <= TX_SEND;
							line_q <= sh_q[TAIL_BITS-1];
							sh_q <= {sh_q[TAIL_BITS-2:0], 1'b0};
						end
					end
				end
				TX_SEND:
				begin
					tmr_q <= bit_done ? '0 : tmr_q + 1'b1;
					if (bit_done)
					begin
						cnt_q <= cnt_q + 1'b1;
						line_q <= sh_q[TAIL_BITS-1];
						sh_q <= {sh_q[TAIL_BITS-2:0], 1'b0};
						if (cnt_q == BCNT_W'(TAIL_BITS - 1))
						begin
							line_q <= LINE_IDLE;
							busy_q <= 1'b0;
							state_q <= TX_IDLE;
						end
					end
				end
				default:
				begin
					state_q <= TX_IDLE;
					busy_q <= 1'b0;
					line_q <= LINE_IDLE;
				end
			endcase
		end
	end

endmodule // twr_tx

// File: design/twr_word_rx.sv
// Purpose: telemetry word receive, check and forward, plus outgoing word assembly
// Assumes: rx line and station address arrive from pins; downstream logic on core_clk
// Notes: preparatory bits are sent and expected as marks (1)
`timescale 1ns/1ns
module twr_word_rx import twr_pkg::*; #(
	parameter int BIT_CYC = BIT_CYC_DEF,
	parameter int ADDR_LSB = ADDR_LSB_DEF,
	parameter int ADDR_W = ADDR_W_DEF,
	parameter logic [PAR_BITS-1:0] PAR_POLY = PAR_POLY_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// serial link from and to the modem
	input wire logic rx_line_in,
	output logic tx_line_out,
	// station configuration strap
	input wire logic [ADDR_W-1:0] station_addr_in,
	// downstream word and events
	output logic [INFO_BITS-1:0] word_out,
	output twr_evt_t word_evt_out,
	output logic [GROUP_W-1:0] group_sel_out,
	// outgoing word request
	input wire twr_tx_req_t tx_req_in,
	output logic tx_busy_out
);

	// ****************************************
	// input synchronisers
	// ****************************************
	logic line_m_q;
	logic line_s_q;
	logic [ADDR_W-1:0] addr_m_q;
	logic [ADDR_W-1:0] addr_s_q;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			line_m_q <= LINE_IDLE;
			line_s_q <= LINE_IDLE;
			addr_m_q <= '0;
			addr_s_q <= '0;
		end
		else
		begin
			line_m_q <= rx_line_in;
			line_s_q <= line_m_q;
			addr_m_q <= station_addr_in;
			addr_s_q <= addr_m_q;
		end
	end

	// ****************************************
	// receive state
	// ****************************************
	twr_rx_state_t state_q;
	twr_rx_state_t state_d;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_d;
	logic [BCNT_W-1:0] bcnt_q;
	logic [BCNT_W-1:0] bcnt_d;
	logic [INFO_BITS-1:0] shreg_q;
	logic [INFO_BITS-1:0] shreg_d;
	logic [PAR_BITS-1:0] gen_q;
	logic [PAR_BITS-1:0] gen_d;
	logic [PAR_BITS-1:0] rxpar_q;
	logic [PAR_BITS-1:0] rxpar_d;

	// ****************************************
	// downstream holding registers
	// ****************************************
	logic [INFO_BITS-1:0] word_q;
	logic [INFO_BITS-1:0] word_d;
	twr_evt_t evt_q;
	twr_evt_t evt_d;
	logic [GROUP_W-1:0] group_q;
	logic [GROUP_W-1:0] group_d;

	// ****************************************
	// decode
	// ****************************************
	// mark span counted in whole half bits, as the sender does, so an odd
	// bit time cannot leave our own looped word a few cycles short
	// a 0 inside the mark span restarts the wait for a full span, so a
	// word with a cut preparatory portion is never heard
	wire [TMR_W-1:0] prep_cyc = TMR_W'(PREP_HALVES * (BIT_CYC / 2));
	wire [TMR_W-1:0] half_last = TMR_W'(BIT_CYC / 2 - 1);
	wire [TMR_W-1:0] bit_last = TMR_W'(BIT_CYC - 1);
	wire prep_seen = tmr_q >= prep_cyc;
	wire half_tick = tmr_q == half_last;
	wire bit_tick = tmr_q == bit_last;
	wire info_last = bcnt_q == BCNT_W'(INFO_BITS - 1);
	wire par_last = bcnt_q == BCNT_W'(PAR_BITS - 1);
	wire par_ok = gen_q == rxpar_q;
	wire [ADDR_W-1:0] rx_addr = shreg_q[ADDR_LSB +: ADDR_W];
	wire addr_match = rx_addr == addr_s_q;
	wire grp_cmd = shreg_q[CMD_GRP_BIT];
	wire [GROUP_W-1:0] rx_group = shreg_q[GROUP_LSB +: GROUP_W];
	wire [TMR_W-1:0] tmr_inc = tmr_q + 1'b1;

	// ****************************************
	// check outcome
	// ****************************************
	// address is looked at only once parity has passed
	wire chk_err = !par_ok;
	wire chk_drop = par_ok && !addr_match;
	wire chk_accept = par_ok && addr_match;
	wire chk_group = chk_accept && grp_cmd;

	// ****************************************
	// receive sequencer
	// ****************************************
	always_comb
	begin
		state_d = state_q;
		tmr_d = tmr_inc;
		bcnt_d = bcnt_q;
		shreg_d = shreg_q;
		gen_d = gen_q;
		rxpar_d = rxpar_q;
		word_d = word_q;
		group_d = group_q;
		evt_d = '0;
		case (state_q)
			RX_HUNT:
			begin
				// time spent at mark, saturating once the prep span is reached
				if (line_s_q == LINE_IDLE)
				begin
					tmr_d = prep_seen ? tmr_q : tmr_inc;
				end
				else if (prep_seen)
				begin
					tmr_d = '0;
					state_d = RX_START;
				end
				else
				begin
					tmr_d = '0;
				end
			end
			RX_START:
			begin
				// confirm the start bit at mid bit and re-centre sampling there
				if (half_tick)
				begin
					tmr_d = '0;
					bcnt_d = '0;
					gen_d = PAR_RST;
					if (line_s_q == 1'b0)
					begin
						state_d = RX_INFO;
					end
					else
					begin
						state_d = RX_HUNT;
					end
				end
			end
			RX_INFO:
			begin
				if (bit_tick)
				begin
					tmr_d = '0;
					shreg_d = {shreg_q[INFO_BITS-2:0], line_s_q};
					gen_d = twr_par_step(gen_q, line_s_q, PAR_POLY);
					bcnt_d = bcnt_q + 1'b1;
					if (info_last)
					begin
						bcnt_d = '0;
						state_d = RX_PARITY;
					end
				end
			end
			RX_PARITY:
			begin
				if (bit_tick)
				begin
					tmr_d = '0;
					rxpar_d = {rxpar_q[PAR_BITS-2:0], line_s_q};
					bcnt_d = bcnt_q + 1'b1;
					if (par_last)
					begin
						bcnt_d = '0;
						state_d = RX_CHECK;
					end
				end
			end
			RX_CHECK:
			begin
				tmr_d = '0;
				state_d = RX_HUNT;
				evt_d.err = chk_err;
				evt_d.drop = chk_drop;
				evt_d.accept = chk_accept;
				evt_d.grp_req = chk_group;
				if (chk_accept)
				begin
					word_d = shreg_q;
				end
				if (chk_group)
				begin
					group_d = rx_group;
				end
			end
			default:
			begin
				tmr_d = '0;
				state_d = RX_HUNT;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_q <= RX_HUNT;
			tmr_q <= '0;
			bcnt_q <= '0;
			shreg_q <= INFO_RST;
			gen_q <= PAR_RST;
			rxpar_q <= PAR_RST;
		end
		else
		begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			bcnt_q <= bcnt_d;
			shreg_q <= shreg_d;
			gen_q <= gen_d;
			rxpar_q <= rxpar_d;
		end
	end

	// holding memory for the last accepted word
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			word_q <= INFO_RST;
		end
		else
		begin
			word_q <= word_d;
		end
	end

	// group number holding memory feeding the group selector
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			group_q <= GROUP_RST;
		end
		else
		begin
			group_q <= group_d;
		end
	end

	// one-cycle event pulses
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			evt_q <= '0;
		end
		else
		begin
			evt_q <= evt_d;
		end
	end

	assign word_out = word_q;
	assign word_evt_out = evt_q;
	assign group_sel_out = group_q;

	// ****************************************
	// outgoing words
	// ****************************************
	twr_tx #(
		.BIT_CYC(BIT_CYC),
		.PAR_POLY(PAR_POLY)
	) u_tx (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tx_req(tx_req_in),
		.tx_busy(tx_busy_out),
		.tx_line(tx_line_out)
	);

endmodule // twr_word_rx

// File: tb/twr_word_rx_monitor.sv
// Purpose: port checks for the word receiver
// Assumes: one clock, rst_n synchronous active low
// Notes: bound to every twr_word_rx
`timescale 1ns/1ns
module twr_word_rx_chk import twr_pkg::*; #(
	parameter int BIT_CYC = BIT_CYC_DEF,
	parameter int ADDR_LSB = ADDR_LSB_DEF,
	parameter int ADDR_W = ADDR_W_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// observed ports
	input wire logic tx_line_out,
	input wire logic [ADDR_W-1:0] station_addr_in,
	input wire logic [INFO_BITS-1:0] word_out,
	input wire twr_evt_t word_evt_out,
	input wire logic [GROUP_W-1:0] group_sel_out,
	input wire twr_tx_req_t tx_req_in,
	input wire logic tx_busy_out
);
	localparam int PREP_T = 11 * (BIT_CYC / 2);
	localparam int PREP_M = PREP_T - 1;
	twr_evt_t e;
	logic [15:0] bcnt_q;
	logic [15:0] bcnt_d;
	assign e = word_evt_out;
	// busy cycles of the word in flight
	assign bcnt_d = tx_busy_out ? bcnt_q + 16'h0001 : 16'h0000;
	always_ff @(posedge core_clk)
	begin
		bcnt_q <= rst_n ? bcnt_d : 16'h0000;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_EVT_EXCL: assert property ($onehot0({e.accept, e.err, e.drop}))
		else $error("event kinds overlap");
	AST_EVT_PULSE: assert property (|e |=> e == 4'h0)
		else $error("event longer than one cycle");
	AST_GRP_REQ: assert property (e.grp_req |-> e.accept && word_out[CMD_GRP_BIT])
		else $error("group request without flag");
	AST_GRP_LOAD: assert property (e.grp_req |-> group_sel_out == word_out[GROUP_LSB+:GROUP_W])
		else $error("group not latched");
	AST_GRP_HOLD: assert property ($changed(group_sel_out) |-> e.grp_req)
		else $error("group changed unasked");
	AST_WORD_HOLD: assert property ($changed(word_out) |-> e.accept)
		else $error("word changed without accept");
	AST_ACC_ADDR: assert property (e.accept |-> word_out[ADDR_LSB+:ADDR_W] == station_addr_in)
		else $error("accepted foreign address");
	AST_TX_TAKE: assert property (tx_req_in.start && !tx_busy_out |=> tx_busy_out)
		else $error("send request not taken");
	AST_TX_PREP: assert property ($rose(tx_busy_out) |-> ##PREP_M tx_line_out ##1 !tx_line_out)
		else $error("prep span wrong");
	AST_TX_LEN: assert property ($fell(tx_busy_out) |-> bcnt_q == PREP_T + TAIL_BITS * BIT_CYC)
		else $error("word length wrong");
	AST_TX_IDLE: assert property (!tx_busy_out |-> tx_line_out)
		else $error("line not idle");
	cover property (e.accept && e.grp_req);
	cover property (e.err);
	cover property (e.drop);
endmodule // twr_word_rx_chk
bind twr_word_rx twr_word_rx_chk #(.BIT_CYC(BIT_CYC), .ADDR_LSB(ADDR_LSB), .ADDR_W(ADDR_W)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .tx_line_out(tx_line_out), .station_addr_in(station_addr_in),
	.word_out(word_out), .word_evt_out(word_evt_out), .group_sel_out(group_sel_out),
	.tx_req_in(tx_req_in), .tx_busy_out(tx_busy_out));

// File: tb/twr_central_model.sv
// Purpose: central station sender on the receive line
// Assumes: called at a falling edge
// Notes: idle line is mark
`timescale 1ns/1ns
module twr_central_model import twr_pkg::*; #(
	parameter int BIT_CYC = 16
) (
	// clock
	input wire logic core_clk,
	// link
	output logic line_out
);
	initial line_out = LINE_IDLE;
	task automatic send_word(input logic [INFO_BITS-1:0] info, input logic [PAR_BITS-1:0] par, input int glitch);
		logic [TAIL_BITS-1:0] bits;
		bits = {1'b0, info, par};
		line_out = 1'b1;
		// a short 0 inside the mark span must restart the receiver's wait
		if (glitch > 0)
		begin
			repeat (glitch) @(negedge core_clk);
			line_out = 1'b0;
			repeat (BIT_CYC / 2) @(negedge core_clk);
			line_out = 1'b1;
		end
		repeat (11 * (BIT_CYC / 2)) @(negedge core_clk);
		for (int i = TAIL_BITS - 1; i >= 0; i--)
		begin
			line_out = bits[i];
			repeat (BIT_CYC) @(negedge core_clk);
		end
		line_out = LINE_IDLE;
	endtask
endmodule // twr_central_model

// File: tb/testbench.sv
// Purpose: self-checking bench for the word receiver
// Assumes: BIT_CYC cut to 16, fixed station strap
// Notes: send path checked by looping the line back
`timescale 1ns/1ns
module testbench import twr_pkg::*;;
	localparam int BC = 16;
	localparam logic [5:0] STN = 6'h2B;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic loop_sel = 1'b0;
	logic model_line;
	logic tx_line;
	logic busy;
	logic [INFO_BITS-1:0] word;
	logic [GROUP_W-1:0] grp;
	twr_evt_t evt;
	twr_evt_t got = 4'h0;
	twr_tx_req_t req = 18'h0_0000;
	logic [15:0] lfsr_q = 16'h2B61;
	logic [INFO_BITS-1:0] exp_word = 17'h0_0000;
	logic [GROUP_W-1:0] exp_grp = 4'h0;
	int n_fail = 0;
	int comparisons = 0;
	always #50 core_clk = ~core_clk;
	twr_central_model #(.BIT_CYC(BC)) u_central (.core_clk(core_clk), .line_out(model_line));
	twr_word_rx #(.BIT_CYC(BC)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.rx_line_in(loop_sel ? tx_line : model_line), .tx_line_out(tx_line), .station_addr_in(STN),
		.word_out(word), .word_evt_out(evt), .group_sel_out(grp), .tx_req_in(req), .tx_busy_out(busy));
	always @(posedge core_clk)
	begin
		if (|evt)
			got <= evt;
	end
	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [PAR_BITS-1:0] exp_par(input logic [INFO_BITS-1:0] v);
		logic [PAR_BITS-1:0] c;
		c = 7'h00;
		for (int i = INFO_BITS - 1; i >= 0; i--)
			c = {c[5:0], 1'b0} ^ ((v[i] ^ c[6]) ? PAR_POLY_DEF : 7'h00);
		return c;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_evt(input twr_evt_t want);
		int k;
		k = 0;
		while (got == 4'h0 && k < 1000)
		begin
			@(negedge core_clk);
			k++;
		end
		if (got == 4'h0)
		begin
			n_fail++;
			end_sim();
		end
		check(got, want);
		check(word, exp_word);
		check(grp, exp_grp);
		got = 4'h0;
		repeat (20) @(negedge core_clk);
	endtask
	// kind 0 plain accept (0 glitch in its mark span if flip[6]), 1 group request, 2 foreign address, 3 bad parity
	task automatic rx_word(input int kind, input logic [PAR_BITS-1:0] flip);
		logic [INFO_BITS-1:0] info;
		twr_evt_t want;
		int glitch;
		glitch = (kind == 0 && flip[6]) ? 40 : 0;
		lfsr_q = lfsr_next(lfsr_q);
		info = {lfsr_q[0], lfsr_q};
		info[ADDR_LSB_DEF+:ADDR_W_DEF] = kind == 2 ? STN ^ (lfsr_q[5:0] | 6'h01) : STN;
		info[CMD_GRP_BIT] = kind == 1;
		want = '{accept: kind < 2, err: kind == 3, drop: kind == 2, grp_req: kind == 1};
		if (kind < 2)
			exp_word = info;
		if (kind == 1)
			exp_grp = info[GROUP_LSB+:GROUP_W];
		u_central.send_word(info, exp_par(info) ^ (kind == 3 ? flip : 7'h00), glitch);
		wait_evt(want);
		$display("receive test kind %0d done", kind);
	endtask
	task automatic tx_word(input logic [INFO_BITS-1:0] info);
		int k;
		info[ADDR_LSB_DEF+:ADDR_W_DEF] = STN;
		loop_sel = 1'b1;
		req = '{start: 1'b1, info: info};
		@(negedge core_clk);
		check(busy, 1'b1);
		req.info = ~info;
		@(negedge core_clk);
		req.start = 1'b0;
		k = 0;
		while (busy !== 1'b0 && k < 1000)
		begin
			@(negedge core_clk);
			k++;
		end
		check(k < 1000, 1'b1);
		exp_word = info;
		if (info[CMD_GRP_BIT])
			exp_grp = info[GROUP_LSB+:GROUP_W];
		wait_evt('{accept: 1'b1, err: 1'b0, drop: 1'b0, grp_req: info[CMD_GRP_BIT]});
		loop_sel = 1'b0;
		@(negedge core_clk);
		$display("send test done");
	endtask
	initial
	begin
		repeat (12) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int i = 0; i < 12; i++)
			rx_word(i % 4, i[2] ? 7'h40 : 7'h01);
		tx_word(17'h1_FFFF);
		lfsr_q = lfsr_next(lfsr_q);
		tx_word({lfsr_q[1], lfsr_q});
		end_sim();
	end
endmodule // testbench
